// ==== src/hsf_map.vh ====
// Register map, field positions, reset values and averaging counts of the
// monitor special-function configuration block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef HSF_MAP_VH
`define HSF_MAP_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define HSF_OFS_TEST_DIGITAL_VALUE 8'h4c
`define HSF_OFS_SPECIAL_FUNCTION 8'h4f

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define HSF_RST_TEST_DIGITAL_VALUE 8'h00
`define HSF_RST_SPECIAL_FUNCTION 8'h00

// ------------------------------------------------------------------
// Special-function fields
// ------------------------------------------------------------------
`define HSF_BIT_SHUTDOWN 0
`define HSF_BIT_CYCLE_MON 1
`define HSF_BIT_ALERT_EN 2
`define HSF_BIT_ALERT_VOLT 3
`define HSF_BIT_OFS_INTERNAL 4
`define HSF_BIT_LOW_AVG 5
`define HSF_WRITABLE_MASK 8'h3f

// ------------------------------------------------------------------
// Averaging counts
// ------------------------------------------------------------------
`define HSF_AVG_REMOTE_FULL 8'h80
`define HSF_AVG_OTHER_FULL 8'h08
`define HSF_AVG_REMOTE_LOW 8'h10
`define HSF_AVG_OTHER_LOW 8'h01

`endif

// ==== src/hsf_avg_sel.v ====
// Averaging-count selector for the measurement sequencer.
// Assumes the low-average configuration bit is a stable register output.
`timescale 1ns/1ps
`include "hsf_map.vh"

module hsf_avg_sel (
    input wire low_avg,
    output wire [7:0] remote_avg_count,
    output wire [7:0] other_avg_count
);

    // 128/8 samples normally; 16/1 when power saving is requested
    assign remote_avg_count = low_avg ? `HSF_AVG_REMOTE_LOW : `HSF_AVG_REMOTE_FULL;
    assign other_avg_count = low_avg ? `HSF_AVG_OTHER_LOW : `HSF_AVG_OTHER_FULL;

endmodule

// ==== src/hsf_pin_mux.v ====
// Role mux for the shared alert / address-bit / reset-pulse pin.
// Assumes all inputs come from flip-flops of the same clock domain.
`timescale 1ns/1ps

module hsf_pin_mux (
    input wire alert_en,
    input wire reset_pin_sel,
    input wire alert_assert,
    input wire reset_pulse_assert,
    output wire pin_drive_low,
    output wire pin_is_address
);

    // ------------------------------------------------------------------
    // Pin role
    // ------------------------------------------------------------------
    // Alert function wins; otherwise the voltage-id top bit picks the role
    assign pin_drive_low = alert_en ? alert_assert :
        (reset_pin_sel & reset_pulse_assert);
    assign pin_is_address = ~alert_en & ~reset_pin_sel;

endmodule

// ==== src/hsf_config.v ====
// Special-function and test-digital-value registers of the hardware
// monitor, with the shared alert pin drive and averaging selection.
// Assumes a register access port from the serial management interface:
// one-cycle write strobe with address and data, read data returned
// combinationally-free from a registered read path one cycle later.
`timescale 1ns/1ps
`include "hsf_map.vh"

// Overview of operation
// - Special-function bit 0 picks sleep (0, default) or shutdown (1).
// - Bit 1 picks continuous monitoring (0, default) or cycle monitoring (1).
// - Bit 2 set makes the shared pin the active-low thermal alert.
// - Bit 3 set lets voltages at or beyond limit pull the alert low.
// - Bit 4 applies temperature offset to external (0) or internal (1).
// - Bit 5 clear: average 128 remote, 8 voltage and internal samples.
// - Bit 5 set: average 16 remote, no averaging elsewhere, saving power.
// - Reserved bits 7:6 are read-only and read as zero.
// - Test digital value register is read/write, clears to zero at reset.
// - With alert off, voltage-id top bit picks address bit or reset pulse.
module hsf_config (
    input wire clk,
    input wire rst_n,
    input wire init,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reset_pin_sel,
    input wire reset_pulse_req,
    input wire temp_over_limit,
    input wire volt_over_limit,
    output reg [7:0] reg_rdata,
    output reg reg_hit,
    output reg shutdown_mode,
    output reg cycle_monitor,
    output reg offset_internal,
    output reg [7:0] remote_avg_count,
    output reg [7:0] other_avg_count,
    output reg [7:0] test_digital_value,
    output reg overtemp_alert_pin_out,
    output reg overtemp_alert_pin_oe,
    output reg bus_address_lsb_pin_en
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [7:0] test_val_q;
    reg [5:0] special_q;

    wire wr_test = reg_wr && (reg_addr == `HSF_OFS_TEST_DIGITAL_VALUE);
    wire wr_special = reg_wr && (reg_addr == `HSF_OFS_SPECIAL_FUNCTION);
    wire [7:0] wdata_kept = reg_wdata & `HSF_WRITABLE_MASK;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_val_q <= `HSF_RST_TEST_DIGITAL_VALUE;
            special_q <= 6'h00;
        end else if (init) begin
            // Initialization clears the same state as power-on reset
            test_val_q <= `HSF_RST_TEST_DIGITAL_VALUE;
            special_q <= 6'h00;
        end else begin
            if (wr_test) begin
                test_val_q <= reg_wdata;
            end
            if (wr_special) begin
                // Bits 7:6 have no storage, so writes to them vanish
                special_q <= wdata_kept[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Derived controls
    // ------------------------------------------------------------------
    wire [7:0] remote_cnt_w;
    wire [7:0] other_cnt_w;
    wire drive_low_w;
    wire addr_role_w;

    // Voltage faults only count when explicitly enabled
    wire alert_cause = temp_over_limit |
        (special_q[`HSF_BIT_ALERT_VOLT] & volt_over_limit);

    hsf_avg_sel u_avg (
        .low_avg(special_q[`HSF_BIT_LOW_AVG]),
        .remote_avg_count(remote_cnt_w),
        .other_avg_count(other_cnt_w)
    );

    hsf_pin_mux u_pin (
        .alert_en(special_q[`HSF_BIT_ALERT_EN]),
        .reset_pin_sel(reset_pin_sel),
        .alert_assert(alert_cause),
        .reset_pulse_assert(reset_pulse_req),
        .pin_drive_low(drive_low_w),
        .pin_is_address(addr_role_w)
    );

    // ------------------------------------------------------------------
    // Registered outputs and read path
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
            shutdown_mode <= 1'b0;
            cycle_monitor <= 1'b0;
            offset_internal <= 1'b0;
            remote_avg_count <= `HSF_AVG_REMOTE_FULL;
            other_avg_count <= `HSF_AVG_OTHER_FULL;
            test_digital_value <= 8'h00;
            overtemp_alert_pin_out <= 1'b0;
            overtemp_alert_pin_oe <= 1'b0;
            bus_address_lsb_pin_en <= 1'b1;
        end else begin
            shutdown_mode <= special_q[`HSF_BIT_SHUTDOWN];
            cycle_monitor <= special_q[`HSF_BIT_CYCLE_MON];
            offset_internal <= special_q[`HSF_BIT_OFS_INTERNAL];
            remote_avg_count <= remote_cnt_w;
            other_avg_count <= other_cnt_w;
            test_digital_value <= test_val_q;
            // Open-drain: only ever drives low
            overtemp_alert_pin_out <= 1'b0;
            overtemp_alert_pin_oe <= drive_low_w;
            bus_address_lsb_pin_en <= addr_role_w;
            reg_hit <= 1'b0;
            if (reg_rd) begin
                if (reg_addr == `HSF_OFS_TEST_DIGITAL_VALUE) begin
                    reg_rdata <= test_val_q;
                    reg_hit <= 1'b1;
                end else if (reg_addr == `HSF_OFS_SPECIAL_FUNCTION) begin
                    // Neither register has reserved-one bits, so no bit is forced high
                    reg_rdata <= {2'b00, special_q};
                    reg_hit <= 1'b1;
                end else begin
                    // Other monitor registers live elsewhere
                    reg_rdata <= 8'h00;
                end
            end
        end
    end

endmodule

// ==== verification/hsf_config_sva.sv ====
// Checker for the special-function configuration block.
// Assumes it is bound to hsf_config and sees its ports only.
`timescale 1ns/1ps
module hsf_config_sva (
    input wire clk, rst_n, init, reg_wr, reg_rd, reset_pin_sel, reset_pulse_req,
    input wire temp_over_limit, volt_over_limit, reg_hit, shutdown_mode, cycle_monitor,
    input wire offset_internal, overtemp_alert_pin_oe, bus_address_lsb_pin_en,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata, remote_avg_count, other_avg_count,
    input wire [7:0] test_digital_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Shadow of alert enable and voltage enable, needed to judge the pin
    reg [1:0] cfg_q;
    always @(posedge clk or negedge rst_n)
        if (!rst_n) cfg_q <= 2'b00;
        else if (init) cfg_q <= 2'b00;
        else if (reg_wr && reg_addr == 8'h4f) cfg_q <= reg_wdata[3:2];
    sequence s_sfw; reg_wr && !init && reg_addr == 8'h4f ##1 !init && !reg_wr; endsequence
    sequence s_tvw; reg_wr && !init && reg_addr == 8'h4c ##1 !init && !reg_wr; endsequence
    property p_mode; s_sfw |=> {offset_internal, cycle_monitor, shutdown_mode} ==
        {$past(reg_wdata[4], 2), $past(reg_wdata[1], 2), $past(reg_wdata[0], 2)}; endproperty
    a_mode: assert property (p_mode) else $error("mode bits wrong");
    property p_avg; s_sfw |=> {remote_avg_count, other_avg_count} ==
        ($past(reg_wdata[5], 2) ? 16'h1001 : 16'h8008); endproperty
    a_avg: assert property (p_avg) else $error("averaging counts wrong");
    property p_tdv; s_tvw |=> test_digital_value == $past(reg_wdata, 2); endproperty
    a_tdv: assert property (p_tdv) else $error("test value wrong");
    property p_rsv; reg_rd && reg_addr == 8'h4f
        |=> reg_hit && reg_rdata[7:6] == 2'b00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_ini; init [*2] |=> test_digital_value == 8'h00 && !shutdown_mode; endproperty
    a_ini: assert property (p_ini) else $error("init did not clear");
    property p_tmp; (cfg_q[0] && temp_over_limit) [*3] |-> overtemp_alert_pin_oe; endproperty
    a_tmp: assert property (p_tmp) else $error("alert not driven");
    property p_vlt; (cfg_q[0] && !temp_over_limit && volt_over_limit) [*3]
        |-> overtemp_alert_pin_oe == $past(cfg_q[1]); endproperty
    a_vlt: assert property (p_vlt) else $error("voltage alert wrong");
    property p_adr; (!cfg_q[0] && !reset_pin_sel) [*3]
        |-> bus_address_lsb_pin_en && !overtemp_alert_pin_oe; endproperty
    a_adr: assert property (p_adr) else $error("address role wrong");
    property p_rpl; (!cfg_q[0] && reset_pin_sel && reset_pulse_req) [*3]
        |-> overtemp_alert_pin_oe && !bus_address_lsb_pin_en; endproperty
    a_rpl: assert property (p_rpl) else $error("reset pulse role wrong");
endmodule
bind hsf_config hsf_config_sva u_sva (.*);

// ==== verification/hsf_config_bench.sv ====
// Self-checking bench for hsf_config, driving its ports directly.
// Assumes a 50 MHz clock and no other bus in front of the registers.
`timescale 1ns/1ps
module hsf_config_bench;
    logic clk = 0, rst_n = 0, init = 0, reg_wr = 0, reg_rd = 0, reset_pin_sel = 0;
    logic reset_pulse_req = 0, temp_over_limit = 0, volt_over_limit = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, remote_avg_count;
    logic [7:0] other_avg_count, test_digital_value;
    logic reg_hit, shutdown_mode, cycle_monitor, offset_internal, overtemp_alert_pin_out;
    logic overtemp_alert_pin_oe, bus_address_lsb_pin_en;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    hsf_config u_dut (.*);
    initial forever #10 clk = ~clk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, logic hit);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        @(negedge clk);
        chk("read data", reg_rdata, exp);
        chk("read hit", reg_hit, hit);
    endtask
    task automatic pins(logic oe, logic adr);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("pin drive", overtemp_alert_pin_oe, oe);
        chk("pin level", overtemp_alert_pin_out, 0);
        chk("address role", bus_address_lsb_pin_en, adr);
        // Hand back on a rising edge so the next stimulus starts there
        @(posedge clk);
    endtask
    task automatic t_modes();
        logic [7:0] d;
        logic [2:0] exp_m;
        logic [15:0] exp_a;
        for (int i = 0; i < 8; i++) begin
            d = (i == 7) ? 8'hc0 : (8'h01 << i);
            exp_m = {d[4], d[1:0]};
            exp_a = d[5] ? 16'h1001 : 16'h8008;
            wr(8'h4f, d);
            chk("modes", {offset_internal, cycle_monitor, shutdown_mode}, exp_m);
            chk("averaging", {remote_avg_count, other_avg_count}, exp_a);
            rd(8'h4f, d & 8'h3f, 1);
        end
    endtask
    task automatic t_tdv();
        wr(8'h4c, 8'ha5);
        wr(8'h4d, 8'h11);
        rd(8'h4c, 8'ha5, 1);
        chk("test value", test_digital_value, 8'ha5);
        rd(8'h4d, 8'h00, 0);
    endtask
    task automatic t_pin();
        wr(8'h4f, 8'h04);
        temp_over_limit <= 1;
        pins(1, 0);
        temp_over_limit <= 0;
        volt_over_limit <= 1;
        pins(0, 0);
        wr(8'h4f, 8'h0c);
        pins(1, 0);
        wr(8'h4f, 8'h00);
        pins(0, 1);
        reset_pin_sel <= 1;
        reset_pulse_req <= 1;
        pins(1, 0);
        reset_pulse_req <= 0;
        pins(0, 0);
    endtask
    task automatic t_init();
        wr(8'h4f, 8'h23);
        @(posedge clk);
        init <= 1;
        repeat (2) @(posedge clk);
        init <= 0;
        rd(8'h4f, 8'h00, 1);
        rd(8'h4c, 8'h00, 1);
        chk("shutdown", shutdown_mode, 0);
    endtask
    // Mid-run reset: both registers must come back cleared
    task automatic t_rst();
        wr(8'h4c, 8'h5a);
        wr(8'h4f, 8'h3f);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk("reset avg", {remote_avg_count, other_avg_count}, 16'h8008);
        chk("reset role", bus_address_lsb_pin_en, 1);
        rd(8'h4f, 8'h00, 1);
        rd(8'h4c, 8'h00, 1);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        chk("reset avg", {remote_avg_count, other_avg_count}, 16'h8008);
        rd(8'h4f, 8'h00, 1);
        rd(8'h4c, 8'h00, 1);
        t_modes();
        t_tdv();
        t_pin();
        t_init();
        t_rst();
        stop_test();
    end
endmodule
